// ==== ddmr_core.sv ====
// mode register, burst ordering, additive latency and dll control core
// assumes mrs/read/write/self-refresh/power-down events arrive as decoded
// one-cycle strobes on clk_sys_i; write data beats arrive through a fifo
`timescale 1ns/1ns
module ddmr_core
    import ddmr_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic mrs_i,
    input wire logic [1:0] mrs_sel_i,
    input wire logic [15:0] mrs_addr_i,
    input wire logic rd_cmd_i,
    input wire logic wr_cmd_i,
    input wire logic [2:0] col_i,
    input wire logic bc_n_i,
    input wire logic sr_enter_i,
    input wire logic sr_exit_i,
    input wire logic pd_enter_i,
    input wire logic pd_exit_i,
    input wire logic dll_locked_i,
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic rd_beat_valid_o,
    output logic [2:0] rd_beat_col_o,
    output logic dq_oe_n_o,
    output logic wr_store_o,
    output logic [2:0] wr_store_col_o,
    output logic [DATA_W-1:0] wr_store_data_o,
    output logic wr_int_start_o,
    output logic dll_run_o,
    output logic dll_rst_o,
    output logic pd_slow_exit_o,
    output logic [15:0] mr0_o,
    output logic wr_odt_ok_o
);
    typedef enum logic [2:0] {
        DDMR_IDLE_ST = 3'h1,
        DDMR_READ_ST = 3'h2,
        DDMR_WRITE_ST = 3'h4
    } ddmr_state_type;

    // beat column for a burst; writes always ascend from the group base
    function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] beat,
                                           input logic ilv, input logic is_wr);
        logic [2:0] c;
        c = 3'h0;
        if (is_wr) begin
            c = beat; // [R07]
        end else if (ilv) begin
            c = start ^ beat; // [R04] [R01]
        end else begin
            c = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])}; // [R03] [R01]
        end
        return c;
    endfunction : beat_col

    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic [2:0] dll_rst_cnt;
    logic in_sr;
    logic in_pd;
    ddmr_state_type state;
    logic [2:0] beat;
    logic [2:0] cur_start;
    logic cur_chop;
    logic [DDMR_DELAY_DEPTH-1:0] rd_pipe;
    logic [DDMR_DELAY_DEPTH-1:0] wr_pipe;
    logic [3:0] cmd_info [DDMR_DELAY_DEPTH];
    logic [4:0] al;
    logic chop_now;
    logic fire_rd;
    logic fire_wr;
    logic fifo_valid;
    logic fifo_ready;
    logic [DATA_W-1:0] fifo_data;
    logic [1:0] bl_mode;

    assign bl_mode = mr0[DDMR_MR0_BL_LSB +: 2];
    // fixed bc4 forces a chop, otf follows bc#: low chops
    assign chop_now = (bl_mode == DDMR_BL_FIX4) ||
                      ((bl_mode == DDMR_BL_OTF) && !bc_n_i); // [R02] [R25]

    // additive latency from mr1 a4:a3: 0 off, 1 cl-1, 2 cl-2 modelled as fixed steps
    always_comb begin
        case (mr1[DDMR_MR1_AL_LSB +: 2])
            2'h1: al = 5'h04;
            2'h2: al = 5'h03;
            default: al = 5'h00;
        endcase
    end

    ddmr_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DDMR_FIFO_DEPTH)
    ) u_wfifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(wdata_valid_i),
        .in_ready_o(wdata_ready_o),
        .in_data_i(wdata_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_data)
    );

    // mode registers; dll reset bit clears itself as the reset count reaches zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mr0 <= DDMR_MR_RESET;
            mr1 <= DDMR_MR_RESET;
            mr2 <= DDMR_MR_RESET;
            dll_rst_cnt <= 3'h0;
        end else begin
            if (mrs_i && mrs_sel_i == DDMR_MRSEL_0) begin
                mr0 <= mrs_addr_i;
                if (mrs_addr_i[DDMR_MR0_DLL_RST]) begin
                    dll_rst_cnt <= 3'(DDMR_DLL_RST_CYC);
                end
            end else if (dll_rst_cnt == 3'h1) begin
                mr0[DDMR_MR0_DLL_RST] <= 1'b0; // [R10]
            end
            if (dll_rst_cnt != 3'h0 && !(mrs_i && mrs_sel_i == DDMR_MRSEL_0)) begin
                dll_rst_cnt <= dll_rst_cnt - 3'h1;
            end
            if (mrs_i && mrs_sel_i == DDMR_MRSEL_1) begin
                mr1 <= mrs_addr_i;
            end
            if (mrs_i && mrs_sel_i == DDMR_MRSEL_2) begin
                mr2 <= mrs_addr_i;
            end
        end
    end

    // self-refresh and power-down tracking drive the dll
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            in_sr <= 1'b0;
            in_pd <= 1'b0;
        end else begin
            if (sr_enter_i) begin
                in_sr <= 1'b1; // [R16]
            end else if (sr_exit_i) begin
                in_sr <= 1'b0; // [R16]
            end
            if (pd_enter_i) begin
                in_pd <= 1'b1;
            end else if (pd_exit_i) begin
                in_pd <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dll_run_o <= 1'b0;
            dll_rst_o <= 1'b0;
            pd_slow_exit_o <= 1'b0;
            mr0_o <= DDMR_MR_RESET;
            wr_odt_ok_o <= 1'b0;
        end else begin
            // frozen in precharge power-down unless a12 keeps it running
            dll_run_o <= !mr1[DDMR_MR1_DLL_DIS] && !in_sr &&
                         !(in_pd && !mr0[DDMR_MR0_PD_KEEP]); // [R13] [R16]
            dll_rst_o <= (dll_rst_cnt != 3'h0);
            pd_slow_exit_o <= !mr0[DDMR_MR0_PD_KEEP]; // [R13]
            mr0_o <= mr0;
            // dynamic termination on writes is only valid with a running dll
            wr_odt_ok_o <= (mr2[DDMR_MR2_RTTWR_LSB +: 2] == 2'h0) ||
                           (dll_run_o && dll_locked_i); // [R18]
        end
    end

    // additive latency pipe: commands accepted at once, issued al+1 cycles later
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_pipe <= '0;
            wr_pipe <= '0;
        end else begin
            // slots drain toward bit zero, which issues the command inside the device
            rd_pipe <= {1'b0, rd_pipe[DDMR_DELAY_DEPTH-1:1]};
            wr_pipe <= {1'b0, wr_pipe[DDMR_DELAY_DEPTH-1:1]};
            if (rd_cmd_i) begin
                rd_pipe[al] <= 1'b1; // [R22]
            end
            if (wr_cmd_i) begin
                // a fixed bc4 write is issued two cycles earlier than bl8 when al is at least two, else in the same slot
                if (bl_mode == DDMR_BL_FIX4 && al >= 5'(DDMR_WR_EARLY)) begin
                    wr_pipe[al - 5'(DDMR_WR_EARLY)] <= 1'b1; // [R08]
                end else begin
                    wr_pipe[al] <= 1'b1; // [R09] [R22]
                end
            end
        end
    end

    // per-slot command attributes follow the pipe
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < DDMR_DELAY_DEPTH - 1; i++) begin
            cmd_info[i] <= cmd_info[i+1];
        end
        cmd_info[DDMR_DELAY_DEPTH-1] <= 4'h0;
        if (rd_cmd_i) begin
            cmd_info[al] <= {chop_now, col_i};
        end
        if (wr_cmd_i) begin
            if (bl_mode == DDMR_BL_FIX4 && al >= 5'(DDMR_WR_EARLY)) begin
                cmd_info[al - 5'(DDMR_WR_EARLY)] <= {chop_now, col_i};
            end else begin
                cmd_info[al] <= {chop_now, col_i};
            end
        end
    end

    assign fire_rd = rd_pipe[0];
    assign fire_wr = wr_pipe[0] && !fire_rd;
    assign fifo_ready = (state == DDMR_WRITE_ST) && !(cur_chop && beat[2]);

    // burst sequencer: one beat per cycle, writes stall until data; eight slots per burst
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= DDMR_IDLE_ST;
            beat <= 3'h0;
            cur_start <= 3'h0;
            cur_chop <= 1'b0;
        end else begin
            case (state)
                DDMR_IDLE_ST: begin
                    if (fire_rd || fire_wr) begin
                        state <= fire_rd ? DDMR_READ_ST : DDMR_WRITE_ST;
                        cur_start <= cmd_info[0][2:0];
                        cur_chop <= cmd_info[0][3];
                        beat <= 3'h0;
                    end
                end
                DDMR_READ_ST: begin
                    beat <= beat + 3'h1;
                    if (beat == 3'(DDMR_BEATS - 1)) begin
                        state <= DDMR_IDLE_ST;
                    end
                end
                DDMR_WRITE_ST: begin
                    // writes wait for data; chopped tail slots pass unused
                    if (fifo_valid || (cur_chop && beat[2])) begin
                        beat <= beat + 3'h1;
                        if (beat == 3'(DDMR_BEATS - 1)) begin
                            state <= DDMR_IDLE_ST;
                        end
                    end
                end
                default: state <= DDMR_IDLE_ST;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_beat_valid_o <= 1'b0;
            rd_beat_col_o <= 3'h0;
            dq_oe_n_o <= 1'b1;
            wr_store_o <= 1'b0;
            wr_store_col_o <= 3'h0;
            wr_store_data_o <= '0;
            wr_int_start_o <= 1'b0;
        end else begin
            wr_int_start_o <= fire_wr && state == DDMR_IDLE_ST;
            if (state == DDMR_READ_ST) begin
                // chopped reads leave drivers off for the last four slots
                rd_beat_valid_o <= !(cur_chop && beat[2]); // [R05]
                dq_oe_n_o <= cur_chop && beat[2]; // [R05]
                // a chop keeps beats 0..3 inside the start group, so one order serves both
                rd_beat_col_o <= beat_col(cur_start, beat, mr0[DDMR_MR0_BT], 1'b0); // [R05]
            end else begin
                rd_beat_valid_o <= 1'b0;
                dq_oe_n_o <= 1'b1;
            end
            wr_store_o <= fifo_valid && fifo_ready;
            if (fifo_valid && fifo_ready) begin
                wr_store_data_o <= fifo_data;
                // bc4 write: a2 picks the group, a1:a0 ignored
                wr_store_col_o <= cur_chop ? {cur_start[2], beat[1:0]}
                                           : beat_col(cur_start, beat, 1'b0, 1'b1); // [R06] [R07]
            end
        end
    end

    AST_DLL_RST_CLEARS: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R10]
        (mrs_i && mrs_sel_i == DDMR_MRSEL_0 && mrs_addr_i[DDMR_MR0_DLL_RST])
        ##1 (!mrs_i)[*4] |=> !mr0[DDMR_MR0_DLL_RST])
        else $error("dll reset bit did not clear");
    AST_CHOP_TRISTATE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R05]
        (state == DDMR_READ_ST && cur_chop && beat[2]) |=> (dq_oe_n_o && !rd_beat_valid_o))
        else $error("chopped read drove tail slots");
    AST_SR_DLL_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R16]
        sr_enter_i |-> ##2 !dll_run_o)
        else $error("dll still running in self-refresh");
    AST_PD_FROZEN: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R13]
        (in_pd && !mr0[DDMR_MR0_PD_KEEP]) |=> !dll_run_o)
        else $error("dll not frozen in slow-exit power-down");
    AST_BL8_WR_ASC: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R07]
        (fifo_valid && fifo_ready && !cur_chop) |=> wr_store_col_o == $past(beat))
        else $error("bl8 write not ascending");
    AST_BC4_WR_GROUP: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R06]
        (fifo_valid && fifo_ready && cur_chop) |=> wr_store_col_o[2] == $past(cur_start[2]))
        else $error("bc4 write group wrong");
    AST_AL_RD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R22]
        (rd_cmd_i && al == 5'h00) |=> fire_rd)
        else $error("read not issued without additive latency");
    AST_AL_RD_HELD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R22]
        (rd_cmd_i && al == 5'h04) |-> ##1 !fire_rd ##4 fire_rd)
        else $error("read not held for additive latency");
    AST_ILV_FIRST: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R04]
        (state == DDMR_READ_ST && beat == 3'h0) |=> rd_beat_col_o == $past(cur_start))
        else $error("first read beat not start column");
endmodule : ddmr_core

// ==== ddmr_ctrl_model.sv ====
// controller-side model: issues mode register sets, read/write commands
// and feeds write beats; assumes the bench calls its tasks at falling edges
`timescale 1ns/1ns
module ddmr_ctrl_model
    import ddmr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic wready_i,
    output logic mrs_o,
    output logic [1:0] mrs_sel_o,
    output logic [15:0] mrs_addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [2:0] col_o,
    output logic bc_n_o,
    output logic wvalid_o,
    output logic [15:0] wdata_o
);
    localparam int MR_GAP = 4;
    initial begin
        {mrs_o, rd_o, wr_o, wvalid_o, bc_n_o, col_o} = 8'h08;
        {mrs_sel_o, mrs_addr_o, wdata_o} = 34'h0;
    end
    // bank bits select the register, only defined address bits are ever set
    task automatic mrs(input logic [1:0] sel, input logic [15:0] addr);
        repeat (MR_GAP) @(negedge clk_sys_i);
        {mrs_o, mrs_sel_o, mrs_addr_o} = {1'b1, sel, addr};
        @(negedge clk_sys_i);
        mrs_o = 1'b0;
        mrs_addr_o = ~addr;
    endtask : mrs
    // released lines show the inverse so stale values never pass as valid
    task automatic cmd(input logic is_wr, input logic [2:0] col, input logic bc_n);
        @(negedge clk_sys_i);
        {rd_o, wr_o, col_o, bc_n_o} = {~is_wr, is_wr, col, bc_n};
        @(negedge clk_sys_i);
        {rd_o, wr_o, col_o, bc_n_o} = {2'h0, ~col, ~bc_n};
    endtask : cmd
    // valid and data held until a rising edge sees ready high
    task automatic push(input int n, input logic [15:0] base, output int taken);
        taken = 0;
        for (int t = 0; t < n + 4 && taken < n; t++) begin
            @(negedge clk_sys_i);
            {wvalid_o, wdata_o} = {1'b1, base + 16'(taken)};
            #1;
            if (wready_i === 1'b1) begin
                taken++;
            end
        end
        @(negedge clk_sys_i);
        wvalid_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask : push
endmodule : ddmr_ctrl_model

// ==== ddmr_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes a single clock domain and an asynchronous active-high reset
`timescale 1ns/1ns
module ddmr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            // registered ready tracks count != depth, so the port comes from a flop
            in_ready_o <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule : ddmr_fifo

// ==== ddmr_pkg.sv ====
// mode register decode constants for the ddr3 mode/burst/dll block
// assumes commands are already decoded to one-cycle strobes on clk_sys_i
// Summary of operation
// R01: mr0 a3 selects sequential or interleaved order
// R02: mr0 a1:a0 picks bc4, bl8 or on-the-fly
// R03: sequential bl8 read rotates within nibbles
// R04: interleaved bl8 read xors start with beat
// R05: bc4 read gives nibble, then tristate four
// R06: bc4 write uses a2 only, ascending order
// R07: bl8 write always ascending zero to seven
// R08: fixed bc4 write starts two cycles early (here only when al is at least two, else like bl8)
// R09: on-the-fly bc4 write starts like bl8
// R10: dll reset bit clears itself after reset
// R11: controller waits dll lock before reads
// R12: controller programs write recovery large enough
// R13: a12 selects dll frozen or kept in powerdown
// R14: controller selects mr1 with ba0 high
// R15: controller writes reserved bits as zero
// R16: dll off in self-refresh, on at exit
// R17: controller keeps cke high during lock
// R18: writes need dll only with dynamic termination
// R19: controller disables nominal termination when dll off
// R20: controller disables dynamic termination when dll off
// R21: controller limits termination during write leveling
// R22: commands held for additive latency internally
// R23: controller selects mr0 with all ba low
// R24: controller respects mrs cycle and update delay
// R25: bc# low chops to four, high gives eight
package ddmr_pkg;
    localparam logic [1:0] DDMR_BL_FIX8 = 2'h0;
    localparam logic [1:0] DDMR_BL_OTF = 2'h1;
    localparam logic [1:0] DDMR_BL_FIX4 = 2'h2;
    localparam int DDMR_MR0_BL_LSB = 0;
    localparam int DDMR_MR0_BT = 3;
    localparam int DDMR_MR0_DLL_RST = 8;
    localparam int DDMR_MR0_PD_KEEP = 12;
    localparam int DDMR_MR1_DLL_DIS = 0;
    localparam int DDMR_MR1_AL_LSB = 3;
    localparam int DDMR_MR2_RTTWR_LSB = 9;
    localparam logic [15:0] DDMR_MR_RESET = 16'h0000;
    localparam int DDMR_WR_EARLY = 2;
    localparam int DDMR_BEATS = 8;
    localparam int DDMR_DLL_RST_CYC = 4;
    localparam int DDMR_FIFO_DEPTH = 8;
    localparam int DDMR_DELAY_DEPTH = 32;
    localparam logic [1:0] DDMR_MRSEL_0 = 2'h0;
    localparam logic [1:0] DDMR_MRSEL_1 = 2'h1;
    localparam logic [1:0] DDMR_MRSEL_2 = 2'h2;
endpackage : ddmr_pkg

// ==== tb_top.sv ====
// self-checking bench for ddmr_core: burst order, write storage, fifo,
// additive latency, dll reset and power-down; inputs change at falling edges
`timescale 1ns/1ns
module tb_top
    import ddmr_pkg::*;
;
    logic clk_sys_i, rst_i, mrs, rd, wr, bc_n, wv, wrdy, dll_locked_i;
    logic sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i;
    logic [1:0] msel;
    logic [15:0] maddr, wd, mr0_o, st_d;
    logic [2:0] col, rcol, st_c;
    logic rvalid, oe_n, st, wst_p, dll_run_o, dll_rst_o, pd_slow, odt_ok;
    int err_count = 0, samples_checked = 0, cyc = 0, wst = 0, lat0, lw8, lat;
    logic [2:0] st_col[$];
    logic [15:0] st_dat[$];
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    ddmr_ctrl_model m (.clk_sys_i(clk_sys_i), .wready_i(wrdy), .mrs_o(mrs), .mrs_sel_o(msel),
        .mrs_addr_o(maddr), .rd_o(rd), .wr_o(wr), .col_o(col), .bc_n_o(bc_n), .wvalid_o(wv),
        .wdata_o(wd));
    ddmr_core #(.DATA_W(16)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mrs_i(mrs),
        .mrs_sel_i(msel), .mrs_addr_i(maddr), .rd_cmd_i(rd), .wr_cmd_i(wr), .col_i(col),
        .bc_n_i(bc_n), .sr_enter_i(sr_enter_i), .sr_exit_i(sr_exit_i), .pd_enter_i(pd_enter_i),
        .pd_exit_i(pd_exit_i), .dll_locked_i(dll_locked_i), .wdata_valid_i(wv),
        .wdata_ready_o(wrdy), .wdata_i(wd), .rd_beat_valid_o(rvalid), .rd_beat_col_o(rcol),
        .dq_oe_n_o(oe_n), .wr_store_o(st), .wr_store_col_o(st_c), .wr_store_data_o(st_d),
        .wr_int_start_o(wst_p), .dll_run_o(dll_run_o), .dll_rst_o(dll_rst_o),
        .pd_slow_exit_o(pd_slow), .mr0_o(mr0_o), .wr_odt_ok_o(odt_ok));
    // count on rising edges, observe on falling ones so nothing races
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    always @(negedge clk_sys_i) begin
        if (st === 1'b1) begin
            st_col.push_back(st_c);
            st_dat.push_back(st_d);
        end
        if (wst_p === 1'b1) wst = cyc;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic fail_out(input string name);
        err_count++;
        $display("Error %s expected done seen timeout", name);
        test_done;
    endtask : fail_out
    task automatic read_burst(input logic [2:0] c, input logic b_n, input logic ilv,
            input logic chop, output int l);
        logic [2:0] e;
        l = 0;
        m.cmd(1'b0, c, b_n);
        while (rvalid !== 1'b1) begin
            l++;
            if (l > 20) fail_out("read start");
            @(negedge clk_sys_i);
        end
        for (int b = 0; b < 8; b++) begin
            e = ilv ? (c ^ 3'(b)) : {c[2] ^ b[2], c[1:0] + 2'(b)};
            if (chop && b > 3) begin
                check("read idle drive", 16'(oe_n), 16'h0001);
            end else begin
                check("read col", 16'(rcol), 16'(e));
                check("read drive", 16'(oe_n), 16'h0000);
            end
            @(negedge clk_sys_i);
        end
    endtask : read_burst
    task automatic write_burst(input logic [2:0] c, input logic b_n, input int n,
            input logic fill, input logic [15:0] base, output int l);
        int got, t0;
        m.push(fill ? n + 2 : n, base, got);
        check("fifo taken", 16'(got), 16'(n));
        if (fill) check("fifo full ready", 16'(wrdy), 16'h0000);
        st_col.delete();
        st_dat.delete();
        t0 = cyc;
        m.cmd(1'b1, c, b_n);
        for (int k = 0; k < 40 && st_col.size() < n; k++) @(negedge clk_sys_i);
        if (st_col.size() < n) fail_out("write stores");
        l = wst - t0;
        for (int b = 0; b < n; b++) begin
            check("store col", 16'(st_col[b]), 16'((n == 4 ? c & 3'h4 : 3'h0) + b));
            check("store data", st_dat[b], base + 16'(b));
        end
        check("fifo drained ready", 16'(wrdy), 16'h0001);
    endtask : write_burst
    task automatic pulse_chk(input logic [3:0] p, input logic run, input logic slow);
        @(negedge clk_sys_i);
        {sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i} = p;
        @(negedge clk_sys_i);
        {sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i} = 4'h0;
        repeat (2) @(negedge clk_sys_i);
        check("dll run", 16'(dll_run_o), 16'(run));
        if (p[1]) check("slow exit", 16'(pd_slow), 16'(slow));
    endtask : pulse_chk
    initial begin
        {rst_i, sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i, dll_locked_i} = 6'h20;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        check("reset drive", 16'(oe_n), 16'h0001);
        check("reset mr0", mr0_o, DDMR_MR_RESET);
        // nominal termination and write leveling stay off in every mr1 write
        m.mrs(DDMR_MRSEL_1, 16'h0000);
        // write recovery keeps its default code: no auto-precharge is modelled
        m.mrs(DDMR_MRSEL_0, 16'h1 << DDMR_MR0_DLL_RST);
        @(negedge clk_sys_i);
        check("dll reset bit set", 16'(mr0_o[DDMR_MR0_DLL_RST]), 16'h0001);
        check("dll reset pulse", 16'(dll_rst_o), 16'h0001);
        repeat (DDMR_DLL_RST_CYC + 2) @(negedge clk_sys_i);
        check("dll reset bit clear", 16'(mr0_o[DDMR_MR0_DLL_RST]), 16'h0000);
        check("dll reset done", 16'(dll_rst_o), 16'h0000);
        // reads only once the dll reports lock, cke never dropped meanwhile
        dll_locked_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            m.mrs(DDMR_MRSEL_0, 16'(i < 2 ? DDMR_BL_FIX8 : i < 4 ? DDMR_BL_FIX4 : DDMR_BL_OTF)
                | (16'(i[0]) << DDMR_MR0_BT));
            read_burst(3'(i + 3), i != 4, i[0], i == 2 || i == 3 || i == 4, lat);
            if (i == 0) lat0 = lat;
        end
        m.mrs(DDMR_MRSEL_0, 16'(DDMR_BL_FIX8) | (16'h1 << DDMR_MR0_BT));
        write_burst(3'h5, 1'b1, 8, 1'b1, 16'h00a0, lat);
        m.mrs(DDMR_MRSEL_1, 16'h1 << DDMR_MR1_AL_LSB);
        read_burst(3'h0, 1'b1, 1'b1, 1'b0, lat);
        check("read latency al", 16'(lat), 16'(lat0 + 4));
        m.mrs(DDMR_MRSEL_1, 16'h2 << DDMR_MR1_AL_LSB);
        read_burst(3'h3, 1'b1, 1'b1, 1'b0, lat);
        check("read latency al2", 16'(lat), 16'(lat0 + 3));
        m.mrs(DDMR_MRSEL_1, 16'h1 << DDMR_MR1_AL_LSB);
        write_burst(3'h2, 1'b1, 8, 1'b0, 16'h00b0, lw8);
        m.mrs(DDMR_MRSEL_0, 16'(DDMR_BL_OTF));
        write_burst(3'h6, 1'b0, 4, 1'b0, 16'h00c0, lat);
        check("otf chop write start", 16'(lat), 16'(lw8));
        m.mrs(DDMR_MRSEL_0, 16'(DDMR_BL_FIX4));
        write_burst(3'h1, 1'b1, 4, 1'b0, 16'h00d0, lat);
        check("fixed chop write start", 16'(lat), 16'(lw8 - DDMR_WR_EARLY));
        pulse_chk(4'h2, 1'b0, 1'b1);
        pulse_chk(4'h1, 1'b1, 1'b0);
        m.mrs(DDMR_MRSEL_0, 16'h1 << DDMR_MR0_PD_KEEP);
        pulse_chk(4'h2, 1'b1, 1'b0);
        pulse_chk(4'h1, 1'b1, 1'b0);
        // dll stays enabled here, so write termination may be switched on
        m.mrs(DDMR_MRSEL_2, 16'h1 << DDMR_MR2_RTTWR_LSB);
        check("odt ok locked", 16'(odt_ok), 16'h0001);
        pulse_chk(4'h8, 1'b0, 1'b0);
        check("odt ok in self-refresh", 16'(odt_ok), 16'h0000);
        pulse_chk(4'h4, 1'b1, 1'b0);
        check("odt ok after exit", 16'(odt_ok), 16'h0001);
        test_done;
    end
endmodule : tb_top
